// *** dv/fxc_ctrl_properties.sv ***
// Checker: port timing relations of the FIFO expansion controller
`timescale 1ns/1ps
module fxc_ctrl_properties
  import fxc_pkg::*;
#(
  parameter int unsigned NDEV = 2
)
(
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o,
  input wire logic              fifo_reset_b,
  input wire logic              fifo_write_b,
  input wire logic              fifo_read_b,
  input wire logic [DATA_W-1:0] fifo_wdata,
  input wire logic [NDEV-1:0]   chain_head_select,
  input wire logic              chain_token_in_0,
  input wire logic              replay_strobe_b,
  input wire logic [NDEV-1:0]   full_flag_b,
  input wire logic [NDEV-1:0]   empty_flag_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [7:0] wlow_cnt_reg;  // Low cycles of the write strobe so far
  // Counter lets the pulse width be checked without a long repetition
  always_ff @(posedge clk)
  begin
    if (!rst_b || fifo_write_b)
      wlow_cnt_reg <= 8'h00;
    else
      wlow_cnt_reg <= wlow_cnt_reg + 8'h01;
  end
  ack_answer_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  head_select_a: assert property ($past(rst_b) |-> chain_head_select == {{(NDEV-1){1'b1}}, 1'b0})
    else $error("first-load levels wrong");
  replay_depth_a: assert property (chain_token_in_0 |-> replay_strobe_b)
    else $error("replay strobed in depth mode");
  strobe_excl_a: assert property (!fifo_write_b |-> fifo_read_b)
    else $error("write and read strobes low together");
  write_width_a: assert property ($rose(fifo_write_b) |-> wlow_cnt_reg >= 8'(STROBE_CYC))
    else $error("write strobe too short");
  wdata_hold_a: assert property (!fifo_write_b && !$past(fifo_write_b) |-> $stable(fifo_wdata))
    else $error("write data moved under strobe");
  write_notfull_a: assert property ($fell(fifo_write_b) |-> full_flag_b != '0)
    else $error("write strobe while full");
  read_notempty_a: assert property ($fell(fifo_read_b) |-> empty_flag_b != '0)
    else $error("read strobe while empty");
  reset_quiet_a: assert property ($rose(fifo_reset_b) |-> $past(fifo_write_b) && $past(fifo_read_b))
    else $error("strobe low at device reset release");
  strap_hold_a: assert property ($rose(fifo_reset_b) |-> $stable(chain_token_in_0))
    else $error("mode strap moved at reset release");
endmodule // fxc_ctrl_properties

// *** dv/fxc_dev_model.sv ***
// Behavioural model of the chained FIFO devices
`timescale 1ns/1ps
module fxc_dev_model
  import fxc_pkg::*;
#(
  parameter int unsigned NDEV  = 2,
  parameter int unsigned DEPTH = 4   // Words per device, small to keep runs short
)
(
  input  wire logic              fifo_reset_b,
  input  wire logic              fifo_write_b,
  input  wire logic              fifo_read_b,
  input  wire logic [DATA_W-1:0] fifo_wdata,
  output logic      [DATA_W-1:0] fifo_rdata,
  input  wire logic [NDEV-1:0]   chain_head_select,
  input  wire logic              chain_token_in_0,
  input  wire logic              replay_strobe_b,
  output logic      [NDEV-1:0]   full_flag_b,
  output logic      [NDEV-1:0]   empty_flag_b,
  output logic                   half_full_flag_b
);
  logic [DATA_W-1:0] mem [NDEV*DEPTH];  // Whole chain as one store
  int                cap = DEPTH;       // Usable words in this mode
  int                cnt = 0;           // Occupancy
  int                wp = 0;
  int                rp = 0;
  logic              depth_mode = 1'b0;
  logic              wr_ok = 1'b0;
  logic              rd_ok = 1'b0;
  logic              half_reg = 1'b1;
  // Every device shows the same flags, so one or all may be watched
  assign full_flag_b      = {NDEV{cnt != cap}};
  assign empty_flag_b     = {NDEV{cnt != 0}};
  assign half_full_flag_b = half_reg;
  // Released outputs show the inverse so a stale sample is caught
  assign fifo_rdata = (!fifo_read_b && rd_ok) ? mem[rp] : ~mem[rp];
  // Reset puts both positions at the start
  always @(negedge fifo_reset_b)
  begin
    cnt = 0;
    wp = 0;
    rp = 0;
    half_reg = 1'b1;
  end
  // Mode taken from the token strap at reset release
  always @(posedge fifo_reset_b)
  begin
    depth_mode = (chain_token_in_0 === 1'b1);
    cap = depth_mode ? NDEV*DEPTH : DEPTH;
  end
  // Write accepted at the falling edge, data latched at the rising edge
  always @(negedge fifo_write_b)
  begin
    wr_ok = fifo_reset_b && cnt < cap;
    if (wr_ok && !depth_mode && cnt + 1 > DEPTH/2)
      half_reg = 1'b0;
  end
  always @(posedge fifo_write_b)
  begin
    if (wr_ok)
    begin
      mem[wp] = fifo_wdata;
      wp = (wp + 1) % cap;
      cnt++;
    end
  end
  // Read refused while empty; pop at the rising edge
  always @(negedge fifo_read_b)
    rd_ok = fifo_reset_b && cnt != 0;
  always @(posedge fifo_read_b)
  begin
    if (rd_ok)
    begin
      rp = (rp + 1) % cap;
      cnt--;
      if (cnt <= DEPTH/2)
        half_reg = 1'b1;
    end
  end
  // Replay rewinds the read position outside depth mode only
  always @(negedge replay_strobe_b)
  begin
    if (!depth_mode)
    begin
      rp = 0;
      cnt = wp;
    end
  end
endmodule // fxc_dev_model

// *** dv/tb.sv ***
// Testbench: Wishbone-driven tests of the FIFO expansion controller
`timescale 1ns/1ps
module tb
  import fxc_pkg::*;
;
  localparam int unsigned NDEV  = 2;
  localparam int unsigned DEPTH = 4;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              cyc = 1'b0;
  logic              stb = 1'b0;
  logic              we = 1'b0;
  logic [3:0]        adr = 4'h0;
  logic [31:0]       wdat = 32'h0000_0000;
  logic [31:0]       dat_o;
  logic              ack, irq, rs_b, wr_b, rd_b, tok0, rp_b, half_b;
  logic [DATA_W-1:0] wd, rdat;
  logic [NDEV-1:0]   head, full_b, empty_b;
  logic [31:0]       rd;           // Last read word
  int                fails = 0;
  int                checks = 0;
  always #2 clk = ~clk;
  fxc_ctrl #(.NDEV(NDEV)) i_dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq(irq),
    .fifo_reset_b(rs_b), .fifo_write_b(wr_b), .fifo_read_b(rd_b), .fifo_wdata(wd), .fifo_rdata(rdat),
    .chain_head_select(head), .chain_token_in_0(tok0), .replay_strobe_b(rp_b), .full_flag_b(full_b),
    .empty_flag_b(empty_b), .half_full_flag_b(half_b));
  fxc_dev_model #(.NDEV(NDEV), .DEPTH(DEPTH)) i_dev (.fifo_reset_b(rs_b), .fifo_write_b(wr_b),
    .fifo_read_b(rd_b), .fifo_wdata(wd), .fifo_rdata(rdat), .chain_head_select(head),
    .chain_token_in_0(tok0), .replay_strobe_b(rp_b), .full_flag_b(full_b), .empty_flag_b(empty_b),
    .half_full_flag_b(half_b));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One classic cycle; held until ack is sampled high
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    rd = dat_o;
    if (n >= 50)
      fails++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Control write, then poll until the order has finished
  task automatic order(input logic [31:0] c);
    int n;
    xfer(1'b1, CTRL_OFF, c);
    n = 0;
    do
    begin
      xfer(1'b0, STAT_OFF, 32'h0000_0000);
      n++;
    end
    while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 200);
    if (n >= 200)
      fails++;
  endtask
  task automatic print_verdict;
    if (fails == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog: the tests need about 8 us
  initial
  begin
    #100000;
    fails++;
    print_verdict;
  end
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'(head), 32'h0000_0002);
    chk(32'(tok0), 32'h0000_0000);
    xfer(1'b0, CTRL_OFF, 32'h0000_0000);
    chk(32'(rd[2:1]), 32'(MODE_RESET_VAL));
    xfer(1'b1, IRQ_MASK_OFF, 32'h0000_0008);
    order(32'h0000_0001);
    chk(32'(rd[STAT_EMPTY_BIT]), 32'h0000_0001);
    order(32'h0000_0010);
    chk(32'(rd[STAT_REFUSED_BIT]), 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0000_0001);
    xfer(1'b0, IRQ_STAT_OFF, 32'h0000_0000);
    chk(32'(rd[EV_REFUSE_BIT]), 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0000_0000);
    // Fill past half, then to full
    for (int i = 0; i < DEPTH; i++)
    begin
      order(32'h0000_0008 | (32'(9'h1A0 + i) << CTRL_WDATA_LSB));
      chk(32'(rd[STAT_HALF_BIT]), 32'(i + 1 > DEPTH/2));
      chk(32'(rd[STAT_FULL_BIT]), 32'(i == DEPTH - 1));
    end
    xfer(1'b0, IRQ_STAT_OFF, 32'h0000_0000);
    chk(32'(rd[3:0]), 32'h0000_0003);
    chk(32'(irq), 32'h0000_0000);
    order(32'h0000_0008);
    chk(32'(rd[STAT_REFUSED_BIT]), 32'h0000_0001);
    // Drain in order until empty
    for (int i = 0; i < DEPTH; i++)
    begin
      order(32'h0000_0010);
      chk(32'(rd[24:16]), 32'(9'h1A0 + i));
      chk(32'(rd[STAT_HALF_BIT]), 32'(DEPTH - 1 - i > DEPTH/2));
      chk(32'(rd[STAT_EMPTY_BIT]), 32'(i == DEPTH - 1));
    end
    // Width mode: replay rewinds the read position to the first word
    order(32'h0000_0003);
    order(32'h0000_0008 | (32'h0000_01C0 << CTRL_WDATA_LSB));
    order(32'h0000_0010);
    chk(32'(rd[STAT_EMPTY_BIT]), 32'h0000_0001);
    order(32'h0000_0020);
    chk(32'(rd[STAT_EMPTY_BIT]), 32'h0000_0000);
    order(32'h0000_0010);
    chk(rd & 32'h01FF_0010, 32'h01C0_0000);
    // Depth mode: replay refused, half-full quiet, full only at chain end
    order(32'h0000_0005);
    chk(32'(tok0), 32'h0000_0001);
    xfer(1'b0, CTRL_OFF, 32'h0000_0000);
    chk(32'(rd[2:1]), 32'(MODE_DEPTH));
    order(32'h0000_0020);
    chk(32'(rd[STAT_REFUSED_BIT]), 32'h0000_0001);
    for (int i = 0; i < NDEV*DEPTH; i++)
    begin
      order(32'h0000_0008 | (32'(9'h150 + i) << CTRL_WDATA_LSB));
      chk(32'(rd[STAT_HALF_BIT]), 32'h0000_0000);
      chk(32'(rd[STAT_FULL_BIT]), 32'(i == NDEV*DEPTH - 1));
    end
    order(32'h0000_0010);
    chk(32'(rd[24:16]), 32'h0000_0150);
    xfer(1'b0, 4'h2, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    print_verdict;
  end
endmodule // tb
bind fxc_ctrl fxc_ctrl_properties #(.NDEV(NDEV)) i_props (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .fifo_reset_b(fifo_reset_b), .fifo_write_b(fifo_write_b),
  .fifo_read_b(fifo_read_b), .fifo_wdata(fifo_wdata), .chain_head_select(chain_head_select),
  .chain_token_in_0(chain_token_in_0), .replay_strobe_b(replay_strobe_b), .full_flag_b(full_flag_b),
  .empty_flag_b(empty_flag_b));

// *** rtl/fxc_ctrl.sv ***
// Host controller that drives a chain of asynchronous FIFO devices
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
module fxc_ctrl
  import fxc_pkg::*;
#(
  parameter int unsigned NDEV = 2                      // Devices in the depth chain
)
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Wishbone classic slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [ADDR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      irq,
  // Device pins, shared across width-expanded parts
  output logic                      fifo_reset_b,      // Device reset, low active
  output logic                      fifo_write_b,      // Write strobe, low active
  output logic                      fifo_read_b,       // Read strobe, low active
  output logic      [DATA_W-1:0]    fifo_wdata,
  input  wire logic [DATA_W-1:0]    fifo_rdata,
  output logic      [NDEV-1:0]      chain_head_select, // First-load level per device
  output logic                      chain_token_in_0,  // Token input of device 0 strap
  output logic                      replay_strobe_b,   // Replay, low active
  input  wire logic [NDEV-1:0]      full_flag_b,
  input  wire logic [NDEV-1:0]      empty_flag_b,
  input  wire logic                 half_full_flag_b
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  fxc_state_type        state_reg;                 // Strobe sequencer
  logic [CNT_W-1:0]     cnt_reg;                   // Phase timer
  logic [1:0]           mode_reg;                  // Configured mode
  logic                 is_read_reg;               // Current strobe is a read
  logic [DATA_W-1:0]    rdata_reg;                 // Last word read
  logic                 refused_reg;               // Last request refused
  logic [EV_W-1:0]      ev_stat_reg;               // Sticky events
  logic [EV_W-1:0]      ev_mask_reg;               // Interrupt mask
  logic [EV_W-1:0]      ev_set;                    // Events this cycle
  logic [2*NDEV+DATA_W:0] pins_sync;               // Device pins after two flops
  logic [2:0]           flags_sync;                // Composite full, empty, half after sync
  logic [1:0]           seen_reg;                  // Empty and full as seen last cycle
  logic                 wb_req;
  logic                 wr_ctrl;
  logic                 rd_istat;
  logic                 busy;
  logic                 want_w;
  logic                 want_r;
  logic                 want_rst;
  logic                 want_rt;

  // ------------------------------------------------------------
  // Composite flags and synchroniser
  // ------------------------------------------------------------
  // Each pin gets its own two flops before any gate sees it
  fxc_sync #(.WIDTH(2*NDEV + DATA_W + 1)) u_sync
  (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in ({fifo_rdata, half_full_flag_b, empty_flag_b, full_flag_b}),
    .sync_out (pins_sync)
  );

  // Composite low only when every device is low: OR of the active-low lines
  assign flags_sync = {pins_sync[2*NDEV], |pins_sync[2*NDEV-1:NDEV], |pins_sync[NDEV-1:0]};

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl  = wb_req && wb_we_i && (wb_adr_i == CTRL_OFF) && wb_sel_i[0];
  assign rd_istat = wb_req && !wb_we_i && (wb_adr_i == IRQ_STAT_OFF);
  assign busy     = (state_reg != FXC_IDLE);
  assign want_rst = wr_ctrl && wb_dat_i[CTRL_RESET_BIT];
  assign want_w   = wr_ctrl && wb_dat_i[CTRL_WRITE_BIT];
  assign want_r   = wr_ctrl && wb_dat_i[CTRL_READ_BIT];
  assign want_rt  = wr_ctrl && wb_dat_i[CTRL_REPLAY_BIT];

  // Ack one cycle after request, drop the next cycle
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_req;
  end

  // Read data mux; unmapped reads return zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      wb_dat_o <= 32'h0000_0000;
    else if (wb_req && !wb_we_i)
      unique case (wb_adr_i)
        CTRL_OFF:     wb_dat_o <= {29'h0000_0000, mode_reg, 1'b0};
        STAT_OFF:     wb_dat_o <= {7'h00, rdata_reg, 11'h000, refused_reg,
                                   !flags_sync[2], !flags_sync[1], !flags_sync[0], busy};
        IRQ_STAT_OFF: wb_dat_o <= {28'h000_0000, ev_stat_reg};
        IRQ_MASK_OFF: wb_dat_o <= {28'h000_0000, ev_mask_reg};
        default:      wb_dat_o <= 32'h0000_0000;
      endcase
  end

  // Mode and write data; mode only changes with a device reset
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      mode_reg   <= MODE_RESET_VAL;
      fifo_wdata <= '0;
    end
    else if (wr_ctrl && !busy)
    begin
      if (want_rst)
        mode_reg <= wb_dat_i[CTRL_MODE_LSB +: 2];
      if (want_w)
        fifo_wdata <= wb_dat_i[CTRL_WDATA_LSB +: DATA_W];
    end
  end

  // Mask register
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      ev_mask_reg <= '0;
    else if (wb_req && wb_we_i && (wb_adr_i == IRQ_MASK_OFF) && wb_sel_i[0])
      ev_mask_reg <= wb_dat_i[EV_W-1:0];
  end

  // ------------------------------------------------------------
  // Strobe sequencer
  // ------------------------------------------------------------
  // One operation at a time; strobes held low for the slowest grade
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_reg       <= FXC_IDLE;
      cnt_reg         <= '0;
      is_read_reg     <= 1'b0;
      refused_reg     <= 1'b0;
      fifo_reset_b    <= 1'b1;
      fifo_write_b    <= 1'b1;
      fifo_read_b     <= 1'b1;
      replay_strobe_b <= 1'b1;
    end
    else
    begin
      unique case (state_reg)
        FXC_IDLE:
        begin
          if (wr_ctrl)
          begin
            refused_reg <= 1'b0;
            if (want_rst)
            begin
              // Strobes stay high through reset and its setup margin
              fifo_reset_b <= 1'b0;
              cnt_reg      <= CNT_W'(RESET_CYC);
              state_reg    <= FXC_RESET;
            end
            else if (want_rt)
            begin
              if (mode_reg == MODE_DEPTH)
                refused_reg <= 1'b1;
              else
              begin
                replay_strobe_b <= 1'b0;
                cnt_reg         <= CNT_W'(STROBE_CYC);
                state_reg       <= FXC_STROBE;
              end
            end
            else if (want_w)
            begin
              // Guard against overflow on composite full
              if (!flags_sync[0])
                refused_reg <= 1'b1;
              else
              begin
                fifo_write_b <= 1'b0;
                cnt_reg      <= CNT_W'(STROBE_CYC);
                state_reg    <= FXC_STROBE;
              end
            end
            else if (want_r)
            begin
              // Device ignores reads when empty, so do not issue one
              if (!flags_sync[1])
                refused_reg <= 1'b1;
              else
              begin
                fifo_read_b <= 1'b0;
                is_read_reg <= 1'b1;
                cnt_reg     <= CNT_W'(STROBE_CYC);
                state_reg   <= FXC_STROBE;
              end
            end
          end
        end
        FXC_RESET:
        begin
          if (cnt_reg == '0)
          begin
            fifo_reset_b <= 1'b1;
            cnt_reg      <= CNT_W'(RECOVERY_CYC);
            state_reg    <= FXC_RECOVER;
          end
          else
            cnt_reg <= cnt_reg - 1'b1;
        end
        FXC_STROBE:
        begin
          if (cnt_reg == '0)
          begin
            fifo_write_b    <= 1'b1;
            fifo_read_b     <= 1'b1;
            replay_strobe_b <= 1'b1;
            cnt_reg         <= CNT_W'(RECOVERY_CYC);
            state_reg       <= FXC_RECOVER;
          end
          else
            cnt_reg <= cnt_reg - 1'b1;
        end
        FXC_RECOVER:
        begin
          if (cnt_reg == '0)
          begin
            // Wait out flag delays plus synchroniser before next op
            is_read_reg <= 1'b0;
            cnt_reg   <= CNT_W'(SETTLE_CYC);
            state_reg <= FXC_SETTLE;
          end
          else
            cnt_reg <= cnt_reg - 1'b1;
        end
        FXC_SETTLE:
        begin
          if (cnt_reg == '0)
            state_reg <= FXC_IDLE;
          else
            cnt_reg <= cnt_reg - 1'b1;
        end
      endcase
    end
  end

  // Word sampled on the last low strobe cycle, taken here two flops later
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rdata_reg <= '0;
    else if (state_reg == FXC_RECOVER && cnt_reg == CNT_W'(RECOVERY_CYC - 1) && is_read_reg)
      rdata_reg <= pins_sync[2*NDEV+1 +: DATA_W];
  end

  // ------------------------------------------------------------
  // Chain straps
  // ------------------------------------------------------------
  // Device 0 is the head; token in high only for depth mode
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      chain_token_in_0  <= 1'b0;
      chain_head_select <= '1;
    end
    else
    begin
      chain_token_in_0  <= (mode_reg == MODE_DEPTH);
      chain_head_select <= {{(NDEV-1){1'b1}}, 1'b0};
    end
  end

  // ------------------------------------------------------------
  // Events and interrupt
  // ------------------------------------------------------------
  // Last cycle's composite flags, so only entry edges raise events
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      seen_reg <= 2'b00;
    else
      seen_reg <= ~flags_sync[1:0];
  end

  always_comb
  begin
    ev_set[EV_DONE_BIT]   = (state_reg == FXC_SETTLE) && (cnt_reg == '0);
    ev_set[EV_FULL_BIT]   = !flags_sync[0] && !seen_reg[0];
    ev_set[EV_EMPTY_BIT]  = !flags_sync[1] && !seen_reg[1];
    ev_set[EV_REFUSE_BIT] = wr_ctrl && (state_reg == FXC_IDLE) &&
                            ((want_rt && !want_rst && mode_reg == MODE_DEPTH) ||
                             (want_w && !want_rst && !want_rt && !flags_sync[0]) ||
                             (want_r && !want_rst && !want_rt && !want_w && !flags_sync[1]));
  end

  // Read clears; a new event in the same cycle wins; irq lags one cycle
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ev_stat_reg <= '0;
      irq         <= 1'b0;
    end
    else
    begin
      ev_stat_reg <= (rd_istat ? '0 : ev_stat_reg) | ev_set;
      irq         <= |(ev_stat_reg & ev_mask_reg);
    end
  end

endmodule // fxc_ctrl

// *** rtl/fxc_pkg.sv ***
// Package: constants shared by the FIFO expansion controller files
package fxc_pkg;

  // ------------------------------------------------------------
  // Data and register layout
  // ------------------------------------------------------------
  localparam int unsigned DATA_W        = 9;            // FIFO word width
  localparam int unsigned ADDR_W        = 4;            // Wishbone byte address width used
  localparam logic [3:0]  CTRL_OFF      = 4'h0;         // Control register
  localparam logic [3:0]  STAT_OFF      = 4'h4;         // Status register
  localparam logic [3:0]  IRQ_STAT_OFF  = 4'h8;         // Sticky event bits
  localparam logic [3:0]  IRQ_MASK_OFF  = 4'hC;         // Interrupt mask

  // Control fields
  localparam int unsigned CTRL_RESET_BIT   = 0;         // Pulse device reset
  localparam int unsigned CTRL_MODE_LSB    = 1;         // 2-bit mode field
  localparam int unsigned CTRL_WRITE_BIT   = 3;         // Request one write
  localparam int unsigned CTRL_READ_BIT    = 4;         // Request one read
  localparam int unsigned CTRL_REPLAY_BIT  = 5;         // Request replay
  localparam int unsigned CTRL_WDATA_LSB   = 16;        // Write data field

  // Status fields
  localparam int unsigned STAT_BUSY_BIT    = 0;
  localparam int unsigned STAT_FULL_BIT    = 1;         // Composite full, high active
  localparam int unsigned STAT_EMPTY_BIT   = 2;         // Composite empty, high active
  localparam int unsigned STAT_HALF_BIT    = 3;
  localparam int unsigned STAT_REFUSED_BIT = 4;
  localparam int unsigned STAT_RDATA_LSB   = 16;

  // Event bits
  localparam int unsigned EV_W          = 4;
  localparam int unsigned EV_DONE_BIT   = 0;
  localparam int unsigned EV_FULL_BIT   = 1;
  localparam int unsigned EV_EMPTY_BIT  = 2;
  localparam int unsigned EV_REFUSE_BIT = 3;

  // Modes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_WIDTH  = 2'h1;
  localparam logic [1:0] MODE_DEPTH  = 2'h2;
  localparam logic [1:0] MODE_RESET_VAL = MODE_SINGLE;

  // ------------------------------------------------------------
  // Timing (ns figures, cycles at 250 MHz)
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned STROBE_MIN_NS   = 120;        // Strobe pulse width, slowest grade
  localparam int unsigned RECOVERY_MIN_NS = 20;         // Strobe recovery
  localparam int unsigned RESET_MIN_NS    = 120;        // Reset pulse width
  localparam int unsigned RESET_SETUP_NS  = 100;        // Strobes high before reset release
  localparam int unsigned ACCESS_MAX_NS   = 120;        // Read access time
  localparam int unsigned FLAG_SETTLE_NS  = 145;        // Longest flag delay

  function automatic int unsigned ns_to_cycles(input int unsigned ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  localparam int unsigned STROBE_CYC   = ns_to_cycles(STROBE_MIN_NS);
  localparam int unsigned RECOVERY_CYC = ns_to_cycles(RECOVERY_MIN_NS);
  localparam int unsigned RESET_CYC    = ns_to_cycles(RESET_MIN_NS + RESET_SETUP_NS);
  localparam int unsigned SETTLE_CYC   = ns_to_cycles(FLAG_SETTLE_NS);
  localparam int unsigned ACCESS_CYC   = ns_to_cycles(ACCESS_MAX_NS);
  localparam int unsigned CNT_W        = 8;

  typedef enum logic [2:0] {
    FXC_IDLE,
    FXC_RESET,
    FXC_STROBE,
    FXC_RECOVER,
    FXC_SETTLE
  } fxc_state_type;

endpackage

// *** rtl/fxc_sync.sv ***
// Two-flop synchroniser bank for the device flag and read data pins
`timescale 1ns/1ps
module fxc_sync
  import fxc_pkg::*;
#(
  parameter int unsigned WIDTH = 3
)
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;   // First flop, read only by the second

  // ------------------------------------------------------------
  // Two stages; flags idle high so reset to ones
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      stage1_reg <= '1;
      sync_out   <= '1;
    end
    else
    begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule // fxc_sync
